// *** common/dlpc_defs.vh ***
`ifndef DLPC_DEFS_VH
`define DLPC_DEFS_VH

// Operating modes
`define DLPC_MODE_W 3
`define DLPC_MODE_SX_DOWN 3'h0
`define DLPC_MODE_SX_UP 3'h1
`define DLPC_MODE_DRAIN 3'h2
`define DLPC_MODE_FILL 3'h3
`define DLPC_MODE_DX_DOWN 3'h4
`define DLPC_MODE_DX_UP 3'h5

// Register byte addresses
`define DLPC_ADDR_W 12
`define DLPC_REG_CTRL 12'h000
`define DLPC_REG_STAT 12'h004
`define DLPC_REG_SENS 12'h008

// Control field positions
`define DLPC_CTRL_MODE_LSB 0
`define DLPC_CTRL_MODE_MSB 2
`define DLPC_CTRL_INV 3
`define DLPC_CTRL_ALT_EN 4
`define DLPC_CTRL_SEP_STOP 5
`define DLPC_CTRL_MAN_B_LEAD 6
`define DLPC_CTRL_RUN 7
`define DLPC_CTRL_W 8
`define DLPC_CTRL_RST 8'h00

// Status field positions
`define DLPC_STAT_A_RUN 0
`define DLPC_STAT_B_RUN 1
`define DLPC_STAT_B_LEAD 2
`define DLPC_STAT_W 3

// Sensor bit positions
`define DLPC_SENS_W 4
`define DLPC_S_LEAD_BEGIN 0
`define DLPC_S_LAG_BEGIN 1
`define DLPC_S_LEAD_HALT 2
`define DLPC_S_LAG_HALT 3

`endif

// *** design/dlpc_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module dlpc_sync #(
    parameter WIDTH = 4
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer i;

    // Three stages, accept change when second and third agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // dlpc_sync
`default_nettype wire

// *** design/dlpc_contact.v ***
`timescale 1ns/1ps
`default_nettype none
module dlpc_contact (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire inverse,
    input wire sensor_closed,
    output reg make_on,
    output reg break_on,
    output reg led_on
);
    // Contact and indicator drive
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            make_on <= 1'b0;
            break_on <= 1'b1;
            led_on <= 1'b0;
        end else begin
            make_on <= run;
            break_on <= ~run;
            led_on <= inverse ? ~sensor_closed : sensor_closed;
        end
    end
endmodule // dlpc_contact
`default_nettype wire

// *** design/dlpc_top.v ***
// Behaviour
// - Inverse polarity darkens the indicator on a closed sensor and direct lights it; make and break follow the pump run state in both.
// - Simplex pump-down starts the pump when the level reaches the begin probe.
// - Simplex pump-down holds the pump until the level falls below the halt probe, then stops.
// - Simplex pump-up starts below the begin probe and runs until the level reaches the halt probe.
// - Drain opens the valve at the begin probe and closes it below the end probe.
// - Fill opens the valve below the begin probe and closes it at the end probe.
// - Duplex pump-down with alternation swaps lead and lag each cycle and starts lead at its begin probe.
// - Duplex pump-down with shared stop starts lag at its begin probe and runs both until below the shared halt.
// - Duplex pump-down with separate stops stops each pump below its own halt probe.
// - Duplex pump-up with alternation and shared stop starts lead and lag as level drops and runs both to the shared halt.
// - Duplex pump-up with separate stops stops each pump when the level reaches its own halt probe.
// - Without alternation a fixed lead order set by the manual jumper is kept.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dlpc_defs.vh"
module dlpc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`DLPC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [`DLPC_SENS_W-1:0] sensor_in,
    output wire pump_a_make,
    output wire pump_a_break,
    output wire pump_a_led,
    output wire pump_b_make,
    output wire pump_b_break,
    output wire pump_b_led
);
    reg [`DLPC_CTRL_W-1:0] ctrl_q;
    reg [31:0] prdata_q;
    reg lead_q;
    reg lag_q;
    reg b_lead_q;
    reg lead_d;
    reg lag_d;
    wire [`DLPC_SENS_W-1:0] sens;
    wire [`DLPC_MODE_W-1:0] mode;
    wire duplex;
    wire up_dir;
    wire lead_stop;
    wire run_a;
    wire run_b;
    wire wr_en;
    wire rd_en;
    wire addr_ok;

    function reached;
        input up;
        input s;
        begin
            // Pump-down: reached when covered; pump-up: reached when uncovered
            reached = up ? ~s : s;
        end
    endfunction

    assign mode = ctrl_q[`DLPC_CTRL_MODE_MSB:`DLPC_CTRL_MODE_LSB];
    assign duplex = (mode == `DLPC_MODE_DX_DOWN) || (mode == `DLPC_MODE_DX_UP);
    assign up_dir = (mode == `DLPC_MODE_SX_UP) || (mode == `DLPC_MODE_FILL) || (mode == `DLPC_MODE_DX_UP);

    dlpc_sync #(
        .WIDTH(`DLPC_SENS_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(sensor_in),
        .sync_out(sens)
    );

    // APB slave
    assign addr_ok = (paddr == `DLPC_REG_CTRL) || (paddr == `DLPC_REG_STAT) || (paddr == `DLPC_REG_SENS);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = psel && penable && !addr_ok;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `DLPC_CTRL_RST;
            prdata_q <= 32'h0;
        end else begin
            if (wr_en && paddr == `DLPC_REG_CTRL && pstrb[0]) begin
                ctrl_q <= pwdata[`DLPC_CTRL_W-1:0];
            end
            if (rd_en) begin
                case (paddr)
                    `DLPC_REG_CTRL: prdata_q <= {{(32-`DLPC_CTRL_W){1'b0}}, ctrl_q};
                    `DLPC_REG_STAT: prdata_q <= {{(32-`DLPC_STAT_W){1'b0}}, b_lead_q, run_b, run_a};
                    `DLPC_REG_SENS: prdata_q <= {{(32-`DLPC_SENS_W){1'b0}}, sens};
                    default: prdata_q <= 32'h0;
                endcase
            end
        end
    end

    // Pump sequencing
    always @* begin
        lead_d = lead_q;
        lag_d = lag_q;
        if (!ctrl_q[`DLPC_CTRL_RUN]) begin
            lead_d = 1'b0;
            lag_d = 1'b0;
        end else begin
            if (reached(up_dir, sens[`DLPC_S_LEAD_BEGIN])) begin
                lead_d = 1'b1;
            end
            if (!reached(up_dir, sens[`DLPC_S_LEAD_HALT]) && !reached(up_dir, sens[`DLPC_S_LEAD_BEGIN])) begin
                lead_d = 1'b0;
            end
            if (duplex) begin
                if (reached(up_dir, sens[`DLPC_S_LAG_BEGIN])) begin
                    lag_d = 1'b1;
                end
                if (ctrl_q[`DLPC_CTRL_SEP_STOP]) begin
                    if (!reached(up_dir, sens[`DLPC_S_LAG_HALT]) && !reached(up_dir, sens[`DLPC_S_LAG_BEGIN])) begin
                        lag_d = 1'b0;
                    end
                end else begin
                    if (!reached(up_dir, sens[`DLPC_S_LEAD_HALT]) && !reached(up_dir, sens[`DLPC_S_LAG_BEGIN])) begin
                        lag_d = 1'b0;
                    end
                end
            end else begin
                lag_d = 1'b0;
            end
        end
    end

    // Valve modes share the simplex sequence
    assign lead_stop = lead_q && !lead_d;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_q <= 1'b0;
            lag_q <= 1'b0;
            b_lead_q <= 1'b0;
        end else begin
            lead_q <= lead_d;
            lag_q <= lag_d;
            if (!ctrl_q[`DLPC_CTRL_ALT_EN]) begin
                b_lead_q <= ctrl_q[`DLPC_CTRL_MAN_B_LEAD];
            end else if (lead_stop && duplex) begin
                b_lead_q <= ~b_lead_q;
            end
        end
    end

    assign run_a = b_lead_q ? lag_q : lead_q;
    assign run_b = b_lead_q ? lead_q : lag_q;

    dlpc_contact u_con_a (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_a),
        .inverse(ctrl_q[`DLPC_CTRL_INV]),
        .sensor_closed(sens[`DLPC_S_LEAD_BEGIN]),
        .make_on(pump_a_make),
        .break_on(pump_a_break),
        .led_on(pump_a_led)
    );

    dlpc_contact u_con_b (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_b),
        .inverse(ctrl_q[`DLPC_CTRL_INV]),
        .sensor_closed(sens[`DLPC_S_LAG_BEGIN]),
        .make_on(pump_b_make),
        .break_on(pump_b_break),
        .led_on(pump_b_led)
    );
endmodule // dlpc_top
`default_nettype wire

// *** bench/dlpc_tank.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlpc_tank (
    input wire logic [2:0] level,
    output logic [3:0] sensor_in
);
    // Probe closes when liquid covers it
    assign sensor_in = {level >= 3'h2, level >= 3'h1, level >= 3'h4, level >= 3'h3};
endmodule // dlpc_tank
`default_nettype wire

// *** bench/dlpc_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlpc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] sensor_in,
    input wire logic pump_a_make,
    input wire logic pump_a_break,
    input wire logic pump_b_make
);
    logic [7:0] ctrl_q;
    logic [3:0] sens_q;
    logic [3:0] quiet_q;
    wire logic acc = psel && penable;
    wire logic mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            sens_q <= 4'h0;
            quiet_q <= 4'h0;
        end else begin
            sens_q <= sensor_in;
            if (acc && pwrite && paddr == 12'h000 && pstrb[0]) begin
                ctrl_q <= pwdata[7:0];
            end
            if (sensor_in != sens_q || (acc && pwrite)) begin
                quiet_q <= 4'h0;
            end else if (quiet_q != 4'hf) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end
    a_contact_pair: assert property (pump_a_break == !pump_a_make) else $error("contact pair");
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_decode: assert property (acc |-> pslverr == !mapped) else $error("pslverr decode");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped data");
    a_sx_start: assert property (quiet_q > 4'h9 && ctrl_q == 8'h80 && sensor_in[0] |-> pump_a_make)
        else $error("pump not started");
    a_sx_stop: assert property (quiet_q > 4'h9 && ctrl_q == 8'h80 && !sensor_in[2] |-> !pump_a_make)
        else $error("pump not stopped");
    a_drain_open: assert property (ctrl_q == 8'h82 && $rose(sensor_in[0]) |-> ##[1:8] pump_a_make)
        else $error("valve not opened");
    a_dx_both_run: assert property (ctrl_q == 8'h94 && $rose(sensor_in[1]) |-> ##[1:8] pump_a_make && pump_b_make)
        else $error("lag not started");
    a_out_stable: assert property (quiet_q > 4'h9 |-> $stable(pump_a_make) && $stable(pump_b_make))
        else $error("output moved");
    cp_both_run: cover property (pump_a_make && pump_b_make);
    cp_unmapped: cover property (acc && pslverr);
    cp_drain: cover property (ctrl_q == 8'h82 && pump_a_make);
endmodule // dlpc_chk
bind dlpc_top dlpc_chk dlpc_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sensor_in, .pump_a_make, .pump_a_break, .pump_b_make);
`default_nettype wire

// *** bench/dlpc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlpc_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, ea;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, seed = 32'h05dd953b;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] level = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, am, ab, al, bm, bb, bl;
    wire logic [3:0] sens;
    int n_mismatch = 0, tests_run = 0, i;
    always #10 pclk = ~pclk;
    dlpc_tank dlpc_tank_inst (.level(level), .sensor_in(sens));
    dlpc_top dlpc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .sensor_in(sens), .pump_a_make(am), .pump_a_break(ab), .pump_a_led(al), .pump_b_make(bm),
        .pump_b_break(bb), .pump_b_led(bl));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic lvl(input logic [2:0] l);
        level <= l;
        repeat (10) @(posedge pclk);
    endtask
    task automatic results;
        $display("tests %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (8) @(posedge pclk);
        chk({ab, am, al}, 3'h4);
        presetn <= 1'h1;
        apb(1'h1, 12'h00c, 32'h80);
        chk(err, 1'h1);
        apb(1'h0, 12'h00c, 0);
        chk({err, rd}, {1'h1, 32'h0});
        apb(1'h0, 12'h000, 0);
        chk(rd, 0);
        $display("registers done");
        for (i = 0; i < 24; i++) begin
            if (i % 12 == 0) begin
                lvl(3'h0);
                ea = 0;
                apb(1'h1, 12'h000, i ? 32'h82 : 32'h80);
            end
            seed = xs(seed);
            lvl(seed[2:0] > 3'h4 ? 3'h4 : seed[2:0]);
            ea = level >= 3'h3 ? 1'h1 : (level >= 3'h1 ? ea : 1'h0);
            chk(am, ea);
            chk(al, sens[0]);
        end
        $display("simplex done");
        apb(1'h1, 12'h000, 32'h88);
        lvl(3'h3);
        chk(al, 0);
        lvl(3'h0);
        apb(1'h1, 12'h000, 32'h94);
        lvl(3'h3);
        chk({bm, am}, 2'h1);
        lvl(3'h4);
        chk({bm, am}, 2'h3);
        chk({bb, bl}, {~bm, sens[1]});
        lvl(3'h1);
        chk({bm, am}, 2'h3);
        lvl(3'h0);
        chk({bm, am}, 2'h0);
        apb(1'h0, 12'h004, 0);
        chk(rd[2:0], 3'h4);
        lvl(3'h3);
        chk({bm, am}, 2'h2);
        lvl(3'h0);
        apb(1'h1, 12'h000, 32'hb4);
        lvl(3'h4);
        lvl(3'h2);
        chk({bm, am}, 2'h3);
        lvl(3'h1);
        chk({bm, am}, 2'h1);
        lvl(3'h0);
        apb(1'h1, 12'h000, 32'hc4);
        for (i = 0; i < 2; i++) begin
            lvl(3'h3);
            chk({bm, am}, 2'h2);
            lvl(3'h0);
        end
        apb(1'h1, 12'h000, 32'h81);
        lvl(3'h0);
        chk(am, 1'h1);
        lvl(3'h4);
        chk(am, 1'h0);
        apb(1'h1, 12'h000, 32'h83);
        lvl(3'h0);
        chk(am, 1'h1);
        lvl(3'h4);
        chk(am, 1'h0);
        apb(1'h1, 12'h000, 32'h95);
        lvl(3'h0);
        chk({bm, am}, 2'h3);
        lvl(3'h4);
        chk({bm, am}, 2'h0);
        apb(1'h0, 12'h004, 0);
        chk(rd[2:0], 3'h4);
        apb(1'h1, 12'h000, 32'hb5);
        lvl(3'h0);
        chk({bm, am}, 2'h3);
        lvl(3'h4);
        chk({bm, am}, 2'h0);
        $display("duplex done");
        results();
    end
endmodule // dlpc_top_tb
`default_nettype wire
